// ---- verilog/accel_queue_pkg.sv ----
// Shared constants for the acceleration output data path
package accel_queue_pkg;
    localparam logic [7:0] ADDR_X_LOW = 8'h32;
    localparam logic [7:0] ADDR_X_HIGH = 8'h33;
    localparam logic [7:0] ADDR_Y_LOW = 8'h34;
    localparam logic [7:0] ADDR_Y_HIGH = 8'h35;
    localparam logic [7:0] ADDR_Z_LOW = 8'h36;
    localparam logic [7:0] ADDR_Z_HIGH = 8'h37;
    localparam logic [7:0] ADDR_QUEUE_CONTROL = 8'h38;
    localparam logic [7:0] ADDR_QUEUE_STATUS = 8'h39;
    localparam logic [7:0] CONTROL_RESET = 8'h00;
    localparam int MODE_MSB = 7;
    localparam int MODE_LSB = 6;
    localparam int TRIG_SRC_BIT = 5;
    localparam int SAMPLES_MSB = 4;
    localparam int TRIG_SEEN_BIT = 7;
    localparam int COUNT_MSB = 5;
    localparam int QUEUE_DEPTH_DEFAULT = 32;
    localparam int AXIS_WIDTH = 16;
    localparam int SAMPLE_WIDTH = 3 * AXIS_WIDTH;
    localparam int FLAG_OVERRUN = 0;
    localparam int FLAG_WATERMARK = 1;
    localparam int FLAG_DATA_READY = 2;

    typedef enum logic [1:0] {
        MODE_BYPASS = 2'h0,
        MODE_COLLECT = 2'h1,
        MODE_STREAM = 2'h2,
        MODE_TRIGGER = 2'h3
    } queue_mode_type;
endpackage

// ---- verilog/sample_fifo.sv ----
// Parameterised first-in first-out buffer with valid/ready on both sides
`timescale 1ns/100ps
module sample_fifo #(
    parameter int WIDTH = 48,
    parameter int DEPTH = 4,
    parameter int CW = $clog2(DEPTH + 1)
) (
    input wire logic clk,
    input wire logic reset_n,
    input wire logic flush,
    input wire logic in_valid,
    output logic in_ready,
    input wire logic [WIDTH-1:0] in_data,
    output logic out_valid,
    input wire logic out_ready,
    output logic [WIDTH-1:0] out_data,
    output logic [CW-1:0] count
);
    localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;

    logic [WIDTH-1:0] mem [DEPTH];
    logic [AW-1:0] wr_ptr_r, wr_ptr_nxt, rd_ptr_r, rd_ptr_nxt;
    logic [CW-1:0] count_r, count_nxt;
    logic do_push, do_pop;

    function automatic logic [AW-1:0] bump(input logic [AW-1:0] p);
        bump = (p == AW'(DEPTH - 1)) ? '0 : p + AW'(1);
    endfunction

    // Full still accepts when the drain side pops in the same cycle
    assign in_ready = (count_r != CW'(DEPTH)) || out_ready;
    assign out_valid = (count_r != '0);
    assign out_data = mem[rd_ptr_r];
    assign count = count_r;
    assign do_push = in_valid && in_ready;
    assign do_pop = out_valid && out_ready;

    always_comb begin
        wr_ptr_nxt = wr_ptr_r;
        rd_ptr_nxt = rd_ptr_r;
        count_nxt = count_r;
        if (flush) begin
            wr_ptr_nxt = '0;
            rd_ptr_nxt = '0;
            count_nxt = '0;
        end else begin
            if (do_push) begin
                wr_ptr_nxt = bump(wr_ptr_r);
            end
            if (do_pop) begin
                rd_ptr_nxt = bump(rd_ptr_r);
            end
            if (do_push && !do_pop) begin
                count_nxt = count_r + CW'(1);
            end else if (do_pop && !do_push) begin
                count_nxt = count_r - CW'(1);
            end
        end
    end

    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            wr_ptr_r <= '0;
            rd_ptr_r <= '0;
            count_r <= '0;
        end else begin
            wr_ptr_r <= wr_ptr_nxt;
            rd_ptr_r <= rd_ptr_nxt;
            count_r <= count_nxt;
        end
    end

    // Storage has no reset; contents are only read behind count
    always_ff @(posedge clk) begin
        if (do_push && !flush) begin
            mem[wr_ptr_r] <= in_data;
        end
    end
endmodule // sample_fifo

// ---- verilog/accel_output_data_fifo.sv ----
// Acceleration output bytes, sample queue and its status flags
`timescale 1ns/100ps
// What this block does
// - Six read-only output bytes at 0x32..0x37
// - Twos complement, low byte at lower address
// - Control bits 7:6 select mode; zero bypasses
// - Collect mode stores until 32, then stops
// - Stream mode keeps newest 32, drops oldest
// - Trigger mode: retain, then collect until full
// - Control bit 5 picks trigger pin
// - Sample count zero raises watermark immediately
// - Count sets watermark level in collect/stream
// - Trigger mode: count is pre-trigger retention
// - Status bit 7 shows trigger occurred
// - Status bits 5:0 show stored entries
// - Any data read burst pops one level
// - 32 queued plus one output stage
// - Ready/overrun flags cleared by data reads; watermark follows the queue level in collect/stream
// - Sleep stops queue input, hides data ready
// - Map bit routes each source to a pin
module accel_output_data_fifo #(
    parameter int QUEUE_DEPTH = accel_queue_pkg::QUEUE_DEPTH_DEFAULT
) (
    input wire logic clk,
    input wire logic reset_n,
    input wire logic sample_valid,
    input wire logic [accel_queue_pkg::AXIS_WIDTH-1:0] x_axis_output,
    input wire logic [accel_queue_pkg::AXIS_WIDTH-1:0] y_axis_output,
    input wire logic [accel_queue_pkg::AXIS_WIDTH-1:0] z_axis_output,
    input wire logic sleep_active,
    input wire logic [7:0] reg_addr,
    input wire logic reg_rd,
    input wire logic reg_wr,
    input wire logic [7:0] reg_wdata,
    input wire logic xfer_end,
    output logic [7:0] reg_rdata,
    input wire logic [2:0] int_enable,
    input wire logic [2:0] int_route_map,
    input wire logic ext_first_irq,
    input wire logic ext_second_irq,
    output logic first_irq_output,
    output logic second_irq_output,
    output logic data_ready,
    output logic watermark,
    output logic overrun
);
    import accel_queue_pkg::*;

    localparam int CW = $clog2(QUEUE_DEPTH + 1);

    logic [7:0] ctl_r, ctl_nxt;
    logic trig_seen_r, trig_seen_nxt;
    logic touched_r, touched_nxt;
    logic [SAMPLE_WIDTH-1:0] out_data_r, out_data_nxt;
    logic out_valid_r, out_valid_nxt;
    logic overrun_r, overrun_nxt;
    logic watermark_r, watermark_nxt;
    logic [7:0] rdata_r, rdata_nxt;
    logic first_pin_r, first_pin_nxt, second_pin_r, second_pin_nxt;
    logic trig_pin_prev_r, trig_pin_prev_nxt;

    queue_mode_type mode;
    logic trig_src;
    logic [SAMPLES_MSB:0] samples;
    logic in_sample, data_rd, read_pop, ctl_write, queue_full;
    logic push, drop, lost, load_out, fifo_pop;
    logic fifo_in_ready, fifo_out_valid;
    logic [SAMPLE_WIDTH-1:0] fifo_out_data, new_sample;
    logic [CW-1:0] entries;
    logic [2:0] routed;
    logic trig_pin, trig_event;

    function automatic logic is_data_addr(input logic [7:0] a);
        is_data_addr = (a >= ADDR_X_LOW) && (a <= ADDR_Z_HIGH);
    endfunction

    assign mode = queue_mode_type'(ctl_r[MODE_MSB:MODE_LSB]);
    assign trig_src = ctl_r[TRIG_SRC_BIT];
    assign samples = ctl_r[SAMPLES_MSB:0];
    assign in_sample = sample_valid && !sleep_active;
    assign new_sample = {z_axis_output, y_axis_output, x_axis_output};
    assign data_rd = reg_rd && is_data_addr(reg_addr);
    assign ctl_write = reg_wr && (reg_addr == ADDR_QUEUE_CONTROL);
    // One pop per burst, however many data bytes it touched
    assign read_pop = xfer_end && (touched_r || data_rd);
    assign queue_full = (entries == CW'(QUEUE_DEPTH));

    sample_fifo #(
        .WIDTH(SAMPLE_WIDTH),
        .DEPTH(QUEUE_DEPTH)
    ) queue_inst (
        .clk(clk),
        .reset_n(reset_n),
        .flush(ctl_write),
        .in_valid(push),
        .in_ready(fifo_in_ready),
        .in_data(new_sample),
        .out_valid(fifo_out_valid),
        .out_ready(fifo_pop),
        .out_data(fifo_out_data),
        .count(entries)
    );

    // Admission per mode
    always_comb begin
        push = 1'b0;
        drop = 1'b0;
        lost = 1'b0;
        unique case (mode)
            MODE_BYPASS: begin
                lost = in_sample && out_valid_r && !read_pop;
            end
            MODE_COLLECT: begin
                push = in_sample && !queue_full;
                lost = in_sample && queue_full;
            end
            MODE_STREAM: begin
                push = in_sample;
                drop = in_sample && queue_full;
                lost = drop;
            end
            MODE_TRIGGER: begin
                if (!trig_seen_r) begin
                    // Zero retention still queues one entry; a drop needs a non-empty queue
                    push = in_sample;
                    drop = in_sample && fifo_out_valid &&
                        (32'(entries) >= 32'(samples));
                end else begin
                    push = in_sample && !queue_full;
                    lost = in_sample && queue_full;
                end
            end
        endcase
    end

    assign load_out = (mode != MODE_BYPASS) && !drop && fifo_out_valid &&
        (!out_valid_r || read_pop);
    assign fifo_pop = drop || load_out;

    // Output stage and burst tracking
    always_comb begin
        out_data_nxt = out_data_r;
        out_valid_nxt = out_valid_r;
        touched_nxt = touched_r;
        if (xfer_end) begin
            touched_nxt = 1'b0;
        end else if (data_rd) begin
            touched_nxt = 1'b1;
        end
        if (mode == MODE_BYPASS && in_sample) begin
            out_data_nxt = new_sample;
            out_valid_nxt = 1'b1;
        end else if (load_out) begin
            out_data_nxt = fifo_out_data;
            out_valid_nxt = 1'b1;
        end else if (read_pop) begin
            out_valid_nxt = 1'b0;
        end
    end

    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            out_data_r <= '0;
            out_valid_r <= 1'b0;
            touched_r <= 1'b0;
        end else begin
            out_data_r <= out_data_nxt;
            out_valid_r <= out_valid_nxt;
            touched_r <= touched_nxt;
        end
    end

    // Control, trigger capture and status flags
    always_comb begin
        ctl_nxt = ctl_r;
        trig_seen_nxt = trig_seen_r;
        overrun_nxt = overrun_r;
        watermark_nxt = 1'b0;
        if (ctl_write) begin
            ctl_nxt = reg_wdata;
            trig_seen_nxt = 1'b0;
        end
        // Event wins over a clear in the same cycle
        if (mode == MODE_TRIGGER && trig_event) begin
            trig_seen_nxt = 1'b1;
        end
        if (lost) begin
            overrun_nxt = 1'b1;
        end else if (read_pop) begin
            overrun_nxt = 1'b0;
        end
        if (ctl_nxt[SAMPLES_MSB:0] == '0) begin
            watermark_nxt = 1'b1;
        end else if (ctl_nxt[MODE_MSB:MODE_LSB] == MODE_COLLECT ||
                ctl_nxt[MODE_MSB:MODE_LSB] == MODE_STREAM) begin
            // Widened compare; a count above the depth never marks
            watermark_nxt = (32'(entries) >=
                32'(ctl_nxt[SAMPLES_MSB:0]));
        end
    end

    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            ctl_r <= CONTROL_RESET;
            trig_seen_r <= 1'b0;
            overrun_r <= 1'b0;
            watermark_r <= 1'b0;
        end else begin
            ctl_r <= ctl_nxt;
            trig_seen_r <= trig_seen_nxt;
            overrun_r <= overrun_nxt;
            watermark_r <= watermark_nxt;
        end
    end

    assign data_ready = out_valid_r && !sleep_active;
    assign watermark = watermark_r;
    assign overrun = overrun_r;

    // Interrupt pins; registered so the trigger edge sees stable levels
    assign routed = int_enable & {data_ready, watermark_r, overrun_r};
    assign trig_pin = trig_src ? second_pin_r : first_pin_r;
    assign trig_event = trig_pin && !trig_pin_prev_r;

    always_comb begin
        first_pin_nxt = |(routed & ~int_route_map) || ext_first_irq;
        second_pin_nxt = |(routed & int_route_map) || ext_second_irq;
        trig_pin_prev_nxt = trig_pin;
    end

    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            first_pin_r <= 1'b0;
            second_pin_r <= 1'b0;
            trig_pin_prev_r <= 1'b0;
        end else begin
            first_pin_r <= first_pin_nxt;
            second_pin_r <= second_pin_nxt;
            trig_pin_prev_r <= trig_pin_prev_nxt;
        end
    end

    assign first_irq_output = first_pin_r;
    assign second_irq_output = second_pin_r;

    // Read data, one cycle after the strobe; unmapped reads zero
    always_comb begin
        rdata_nxt = rdata_r;
        if (reg_rd) begin
            unique case (reg_addr)
                ADDR_X_LOW: rdata_nxt = out_data_r[7:0];
                ADDR_X_HIGH: rdata_nxt = out_data_r[15:8];
                ADDR_Y_LOW: rdata_nxt = out_data_r[23:16];
                ADDR_Y_HIGH: rdata_nxt = out_data_r[31:24];
                ADDR_Z_LOW: rdata_nxt = out_data_r[39:32];
                ADDR_Z_HIGH: rdata_nxt = out_data_r[47:40];
                ADDR_QUEUE_CONTROL: rdata_nxt = ctl_r;
                ADDR_QUEUE_STATUS: rdata_nxt = {trig_seen_r, 1'b0,
                    (COUNT_MSB + 1)'(entries)};
                default: rdata_nxt = 8'h00;
            endcase
        end
    end

    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            rdata_r <= 8'h00;
        end else begin
            rdata_r <= rdata_nxt;
        end
    end

    assign reg_rdata = rdata_r;

    default clocking cb @(posedge clk); endclocking
    default disable iff (!reset_n);

    a_queue_bound: assert property (entries <= CW'(QUEUE_DEPTH))
        else $error("queue holds more than its depth");
    a_push_accepted: assert property (push |-> fifo_in_ready)
        else $error("queue refused an admitted sample");
    a_collect_stops: assert property (
        (mode == MODE_COLLECT && queue_full && !ctl_write && !fifo_pop)
        |=> queue_full)
        else $error("collect mode stored past full");
    a_stream_keeps: assert property (
        (mode == MODE_STREAM && queue_full && in_sample && !ctl_write)
        |=> queue_full)
        else $error("stream mode lost its full history");
    a_zero_mark: assert property (
        (ctl_write && reg_wdata[SAMPLES_MSB:0] == '0) |=> watermark)
        else $error("zero count did not raise watermark");
    a_mark_level: assert property (
        (!ctl_write && samples != '0 && mode == MODE_STREAM &&
        32'(entries) >= 32'(samples)) |=> watermark)
        else $error("watermark missing at level");
    a_pop_once: assert property (
        (read_pop && !load_out && !(mode == MODE_BYPASS && in_sample))
        |=> !out_valid_r)
        else $error("read burst did not pop output");
    a_sleep_quiet: assert property (
        sleep_active |-> !data_ready && !push)
        else $error("sleep still delivers samples");
    a_trig_flag: assert property (
        (mode == MODE_TRIGGER && trig_event && !ctl_write) |=> trig_seen_r)
        else $error("trigger flag not set");
    a_overrun_set: assert property (lost |=> overrun [*1])
        else $error("overrun not flagged");
    a_route_first: assert property (
        (routed[FLAG_OVERRUN] && !int_route_map[FLAG_OVERRUN])
        |=> first_irq_output)
        else $error("overrun not routed to first pin");
    a_status_read: assert property (
        (reg_rd && reg_addr == ADDR_QUEUE_STATUS)
        |=> rdata_r == {$past(trig_seen_r), 1'b0,
        (COUNT_MSB + 1)'($past(entries))})
        else $error("status byte mismatch");

    c_stream_wrap: cover property (mode == MODE_STREAM && drop);
    c_trigger_hit: cover property (mode == MODE_TRIGGER && trig_event);
    c_collect_full: cover property (mode == MODE_COLLECT && lost);
    c_burst_pop: cover property (read_pop && load_out);
endmodule // accel_output_data_fifo

// ---- dv/host_model.sv ----
// Host processor model driving the register port of the data path
`timescale 1ns/100ps
module host_model (
    input wire logic clk,
    output logic [7:0] reg_addr,
    output logic reg_rd,
    output logic reg_wr,
    output logic [7:0] reg_wdata,
    output logic xfer_end
);
    initial begin
        reg_addr = 8'h00;
        reg_rd = 1'b0;
        reg_wr = 1'b0;
        reg_wdata = 8'h00;
        xfer_end = 1'b0;
    end

    // Idle bus shows inverted values so stale data cannot pass
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge clk);
        reg_wr <= 1'b1;
        reg_addr <= a;
        reg_wdata <= d;
        @(posedge clk);
        reg_wr <= 1'b0;
        reg_addr <= ~a;
        reg_wdata <= ~d;
    endtask

    // One burst per sample keeps its bytes together
    task automatic rd(input logic [7:0] a, input int n);
        for (int i = 0; i < n; i++) begin
            @(posedge clk);
            reg_rd <= 1'b1;
            reg_addr <= a + 8'(i);
            xfer_end <= (i == n - 1);
        end
        @(posedge clk);
        reg_rd <= 1'b0;
        xfer_end <= 1'b0;
        reg_addr <= ~a;
    endtask
endmodule // host_model

// ---- dv/accel_output_data_fifo_tb.sv ----
// Self-checking bench for the acceleration output data path
`timescale 1ns/100ps
module accel_output_data_fifo_tb;
    import accel_queue_pkg::*;
    localparam int D = 4;
    logic clk = 1'b0;
    logic reset_n = 1'b0;
    logic sample_valid = 1'b0;
    logic sleep_active = 1'b0;
    logic [AXIS_WIDTH-1:0] x_s = '0, y_s = '0, z_s = '0;
    logic [2:0] int_enable = 3'h0, int_route_map = 3'h0;
    logic ext_first_irq = 1'b0, ext_second_irq = 1'b0;
    logic [7:0] reg_addr, reg_wdata, reg_rdata;
    logic reg_rd, reg_wr, xfer_end, pin1, pin2;
    logic data_ready, watermark, overrun;
    logic rd_d = 1'b0;
    logic [7:0] exp_q[$];
    logic [7:0] exp_b;
    logic [SAMPLE_WIDTH-1:0] smp[8];
    int mismatches = 0, n_compared = 0, cycles = 0;

    always #50 clk = ~clk;

    host_model u_host (.clk(clk), .reg_addr(reg_addr), .reg_rd(reg_rd),
        .reg_wr(reg_wr), .reg_wdata(reg_wdata), .xfer_end(xfer_end));

    accel_output_data_fifo #(.QUEUE_DEPTH(D)) u_dut (.clk(clk),
        .reset_n(reset_n), .sample_valid(sample_valid),
        .x_axis_output(x_s), .y_axis_output(y_s), .z_axis_output(z_s),
        .sleep_active(sleep_active), .reg_addr(reg_addr),
        .reg_rd(reg_rd), .reg_wr(reg_wr), .reg_wdata(reg_wdata),
        .xfer_end(xfer_end), .reg_rdata(reg_rdata),
        .int_enable(int_enable), .int_route_map(int_route_map),
        .ext_first_irq(ext_first_irq), .ext_second_irq(ext_second_irq),
        .first_irq_output(pin1), .second_irq_output(pin2),
        .data_ready(data_ready), .watermark(watermark),
        .overrun(overrun));

    task automatic check(input string name, input logic [7:0] seen,
                         input logic [7:0] exp);
        n_compared++;
        if (seen !== exp) begin
            mismatches++;
            $display("unexpected %s: expected %h seen %h", name, exp, seen);
        end
    endtask

    task automatic conclude();
        $display("compared %0d mismatches %0d", n_compared, mismatches);
        if (mismatches == 0 && n_compared > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask

    // Read data lands on the taking edge and is checked at the falling edge after it
    always @(posedge clk) rd_d <= reg_rd;
    always @(negedge clk) begin
        if (rd_d) begin
            exp_b = exp_q.size() > 0 ? exp_q.pop_front() : 8'hxx;
            check("reg_rdata", reg_rdata, exp_b);
        end
    end

    always @(posedge clk) begin
        cycles++;
        if (cycles == 6000) begin
            mismatches++;
            $display("timeout after %0d cycles", cycles);
            conclude();
        end
    end

    task automatic put(input int i);
        @(posedge clk);
        smp[i] = SAMPLE_WIDTH'({$urandom(), $urandom()});
        sample_valid <= 1'b1;
        {z_s, y_s, x_s} <= smp[i];
        @(posedge clk);
        sample_valid <= 1'b0;
        repeat (3) @(posedge clk);
    endtask

    task automatic rdchk(input logic [7:0] a, input logic [7:0] e);
        exp_q.push_back(e);
        u_host.rd(a, 1);
        repeat (2) @(posedge clk);
    endtask

    task automatic expect_sample(input int i);
        for (int b = 0; b < 6; b++) exp_q.push_back(smp[i][8*b +: 8]);
        u_host.rd(ADDR_X_LOW, 6);
        repeat (3) @(posedge clk);
    endtask

    task automatic setctl(input logic [7:0] c);
        u_host.wr(ADDR_QUEUE_CONTROL, c);
        repeat (2) @(posedge clk);
    endtask

    task automatic flags(input logic wm, input logic ov, input logic dr);
        @(negedge clk);
        check("watermark", {7'h0, watermark}, {7'h0, wm});
        check("overrun", {7'h0, overrun}, {7'h0, ov});
        check("data_ready", {7'h0, data_ready}, {7'h0, dr});
    endtask

    task automatic pulse(input logic second);
        @(posedge clk);
        ext_first_irq <= !second;
        ext_second_irq <= second;
        repeat (3) @(posedge clk);
        ext_first_irq <= 1'b0;
        ext_second_irq <= 1'b0;
        repeat (3) @(posedge clk);
    endtask

    initial begin
        void'($urandom(32'h9360));
        repeat (16) @(posedge clk);
        reset_n <= 1'b1;
        repeat (2) @(posedge clk);
        flags(1'b1, 1'b0, 1'b0);
        rdchk(ADDR_QUEUE_STATUS, 8'h00);
        rdchk(8'h3A, 8'h00);
        // Bypass: unread sample overwritten
        put(0);
        put(1);
        flags(1'b1, 1'b1, 1'b1);
        expect_sample(1);
        flags(1'b1, 1'b0, 1'b0);
        @(posedge clk);
        int_enable <= 3'b100;
        int_route_map <= 3'b100;
        put(2);
        @(negedge clk);
        check("second pin", {7'h0, pin2}, 8'h01);
        check("first pin", {7'h0, pin1}, 8'h00);
        @(posedge clk);
        int_route_map <= 3'b000;
        repeat (2) @(negedge clk);
        check("first pin", {7'h0, pin1}, 8'h01);
        check("second pin", {7'h0, pin2}, 8'h00);
        expect_sample(2);
        @(posedge clk);
        int_enable <= 3'b000;
        $display("test bypass done");
        // Collect mode fills, then refuses
        setctl(8'h43);
        for (int i = 0; i <= D; i++) put(i);
        flags(1'b1, 1'b0, 1'b1);
        rdchk(ADDR_QUEUE_STATUS, 8'(D));
        put(7);
        flags(1'b1, 1'b1, 1'b1);
        @(posedge clk);
        int_enable <= 3'b001;
        repeat (2) @(negedge clk);
        check("first pin", {7'h0, pin1}, 8'h01);
        @(posedge clk);
        int_enable <= 3'b000;
        expect_sample(0);
        flags(1'b1, 1'b0, 1'b1);
        expect_sample(1);
        flags(1'b0, 1'b0, 1'b1);
        for (int i = 2; i <= D; i++) expect_sample(i);
        flags(1'b0, 1'b0, 1'b0);
        $display("test collect done");
        // Stream mode drops the oldest queued sample
        setctl(8'h83);
        for (int i = 0; i <= D + 1; i++) put(i);
        flags(1'b1, 1'b1, 1'b1);
        rdchk(ADDR_QUEUE_STATUS, 8'(D));
        expect_sample(0);
        for (int i = 2; i <= D + 1; i++) expect_sample(i);
        $display("test stream done");
        // Trigger source select; count kept nonzero
        setctl(8'hE2);
        pulse(1'b0);
        rdchk(ADDR_QUEUE_STATUS, 8'h00);
        pulse(1'b1);
        rdchk(ADDR_QUEUE_STATUS, 8'h80);
        setctl(8'hC2);
        rdchk(ADDR_QUEUE_STATUS, 8'h00);
        pulse(1'b0);
        for (int i = 0; i <= D + 1; i++) put(i);
        flags(1'b0, 1'b1, 1'b1);
        rdchk(ADDR_QUEUE_STATUS, 8'h80 | 8'(D));
        for (int i = 0; i <= D; i++) expect_sample(i);
        // Pre-trigger queue keeps only the newest count entries; the first sample stays in the output stage
        setctl(8'hC2);
        for (int i = 0; i < 4; i++) put(i);
        rdchk(ADDR_QUEUE_STATUS, 8'h02);
        pulse(1'b0);
        rdchk(ADDR_QUEUE_STATUS, 8'h82);
        expect_sample(0);
        expect_sample(2);
        expect_sample(3);
        $display("test trigger done");
        // Zero count and sleep
        setctl(8'h80);
        flags(1'b1, 1'b0, 1'b0);
        @(posedge clk);
        sleep_active <= 1'b1;
        put(0);
        flags(1'b1, 1'b0, 1'b0);
        rdchk(ADDR_QUEUE_STATUS, 8'h00);
        @(posedge clk);
        sleep_active <= 1'b0;
        $display("test sleep done");
        conclude();
    end
endmodule // accel_output_data_fifo_tb
